// [common/bio_pkg.sv]
// package: register map, reset values and widths for the bidirectional io ports
package bio_pkg;

  // ***************************************************************
  // register indices on the data memory port
  // ***************************************************************
  localparam logic [3:0] ADR_PORT_A_DATA      = 4'h0;
  localparam logic [3:0] ADR_PORT_A_DIRECTION = 4'h1;
  localparam logic [3:0] ADR_PORT_A_PULLUP    = 4'h2;
  localparam logic [3:0] ADR_PORT_A_WAKE      = 4'h3;
  localparam logic [3:0] ADR_PORT_B_DATA      = 4'h4;
  localparam logic [3:0] ADR_PORT_B_DIRECTION = 4'h5;
  localparam logic [3:0] ADR_PORT_B_PULLUP    = 4'h6;
  localparam logic [3:0] ADR_PORT_C_DATA      = 4'h8;
  localparam logic [3:0] ADR_PORT_C_DIRECTION = 4'h9;
  localparam logic [3:0] ADR_PORT_C_PULLUP    = 4'ha;
  localparam logic [3:0] ADR_STRENGTH         = 4'hb;

  // ***************************************************************
  // reset values and field positions
  // ***************************************************************
  localparam logic [7:0] RST_DATA      = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PULLUP    = 8'h00;
  localparam logic [7:0] RST_WAKE      = 8'h00;
  localparam logic       RST_STRENGTH  = 1'h0;
  localparam int         STRONG_PULLUP_BIT = 0;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // port index, one value per port and one for none
  typedef enum logic [1:0] {
    BIO_PORT_A = 2'b00,
    BIO_PORT_B = 2'b01,
    BIO_PORT_C = 2'b10,
    BIO_PORT_NONE = 2'b11
  } bio_port_t;

endpackage : bio_pkg

// [rtl/bio_port_slice.sv]
// one eight-pin port: data latch, direction, pull-high and read mux
`timescale 1ns/1ps
module bio_port_slice #(
  parameter logic [7:0] PIN_MASK = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       wr_data,
  input  wire logic       wr_dir,
  input  wire logic       wr_pu,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] pin_nmos,
  output logic      [7:0] data_q,
  output logic      [7:0] dir_q,
  output logic      [7:0] pu_q,
  output logic      [7:0] rd_val,
  output logic      [7:0] oe_nxt,
  output logic      [7:0] pu_nxt
);

  // ***************************************************************
  // control latches
  // ***************************************************************
  // unimplemented data and pull-high bits never store, unimplemented direction bits are held at one; reads mask them to zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_q <= bio_pkg::RST_DATA;
      dir_q  <= bio_pkg::RST_DIRECTION;
      pu_q   <= bio_pkg::RST_PULLUP;
    end
    else
    begin
      if (wr_data) data_q <= wdata & PIN_MASK;
      if (wr_dir)  dir_q  <= wdata | ~PIN_MASK;
      if (wr_pu)   pu_q   <= wdata & PIN_MASK;
    end
  end

  // ***************************************************************
  // read mux and pin controls
  // ***************************************************************
  // inputs read the live pin, outputs read the latch; no input latching
  assign rd_val = ((dir_q & pin_in) | (~dir_q & data_q)) & PIN_MASK;
  assign oe_nxt = ~dir_q & PIN_MASK;
  // pull-high only for a digital input or an nmos output
  assign pu_nxt = pu_q & (dir_q | pin_nmos) & PIN_MASK;

endmodule : bio_port_slice

// [rtl/bio_ports.sv]
// top: three bidirectional io ports with pull-high and port a wake-up
// Contract
// - output latch holds written value until rewritten
// - input reads sample the live pin, no latching
// - bits without a pin read as zero
// - direction one is input, zero is output
// - reading an output pin returns latch contents
// - per-pin pull-high enables, cleared at reset
// - pull-high acts only for digital input or nmos output
// - one global bit selects weak or strong pull-high, reset zero
// - strength bit ignored on pins without pull-high enabled
// - falling edge on enabled port a pin in low power wakes core
// - per-pin wake enables on port a, cleared at reset
// - wake acts only for input pins while in idle or sleep
// - direction bits reset to one, all pins inputs
`timescale 1ns/1ps
module bio_ports #(
  parameter logic [7:0] PORT_A_MASK = 8'hff,
  parameter logic [7:0] PORT_B_MASK = 8'hff,
  parameter logic [7:0] PORT_C_MASK = 8'h3f
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_ff,
  input  wire logic       core_low_power,
  input  wire logic [7:0] port_a_nmos,
  input  wire logic [7:0] port_b_nmos,
  input  wire logic [7:0] port_c_nmos,
  input  wire logic [7:0] port_a_in,
  input  wire logic [7:0] port_b_in,
  input  wire logic [7:0] port_c_in,
  output logic      [7:0] port_a_out_ff,
  output logic      [7:0] port_b_out_ff,
  output logic      [7:0] port_c_out_ff,
  output logic      [7:0] port_a_oe_ff,
  output logic      [7:0] port_b_oe_ff,
  output logic      [7:0] port_c_oe_ff,
  output logic      [7:0] port_a_pu_ff,
  output logic      [7:0] port_b_pu_ff,
  output logic      [7:0] port_c_pu_ff,
  output logic            strong_pullup_ff,
  output logic            wake_req_ff
);

  // ***************************************************************
  // address decode
  // ***************************************************************
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  wire logic wr_a_data = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_A_DATA);
  wire logic wr_a_dir  = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_A_DIRECTION);
  wire logic wr_a_pu   = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_A_PULLUP);
  wire logic wr_a_wake = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_A_WAKE);
  wire logic wr_b_data = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_B_DATA);
  wire logic wr_b_dir  = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_B_DIRECTION);
  wire logic wr_b_pu   = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_B_PULLUP);
  wire logic wr_c_data = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_C_DATA);
  wire logic wr_c_dir  = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_C_DIRECTION);
  wire logic wr_c_pu   = reg_wr & hit(reg_addr, bio_pkg::ADR_PORT_C_PULLUP);
  wire logic wr_str    = reg_wr & hit(reg_addr, bio_pkg::ADR_STRENGTH);

  // ***************************************************************
  // port slices
  // ***************************************************************
  logic [7:0] a_data, a_dir, a_pu, a_rd, a_oe, a_pun;
  logic [7:0] b_data, b_dir, b_pu, b_rd, b_oe, b_pun;
  logic [7:0] c_data, c_dir, c_pu, c_rd, c_oe, c_pun;

  bio_port_slice #(.PIN_MASK(PORT_A_MASK)) u_port_a (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_data  (wr_a_data),
    .wr_dir   (wr_a_dir),
    .wr_pu    (wr_a_pu),
    .wdata    (reg_wdata),
    .pin_in   (port_a_in),
    .pin_nmos (port_a_nmos),
    .data_q   (a_data),
    .dir_q    (a_dir),
    .pu_q     (a_pu),
    .rd_val   (a_rd),
    .oe_nxt   (a_oe),
    .pu_nxt   (a_pun)
  );

  bio_port_slice #(.PIN_MASK(PORT_B_MASK)) u_port_b (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_data  (wr_b_data),
    .wr_dir   (wr_b_dir),
    .wr_pu    (wr_b_pu),
    .wdata    (reg_wdata),
    .pin_in   (port_b_in),
    .pin_nmos (port_b_nmos),
    .data_q   (b_data),
    .dir_q    (b_dir),
    .pu_q     (b_pu),
    .rd_val   (b_rd),
    .oe_nxt   (b_oe),
    .pu_nxt   (b_pun)
  );

  bio_port_slice #(.PIN_MASK(PORT_C_MASK)) u_port_c (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr_data  (wr_c_data),
    .wr_dir   (wr_c_dir),
    .wr_pu    (wr_c_pu),
    .wdata    (reg_wdata),
    .pin_in   (port_c_in),
    .pin_nmos (port_c_nmos),
    .data_q   (c_data),
    .dir_q    (c_dir),
    .pu_q     (c_pu),
    .rd_val   (c_rd),
    .oe_nxt   (c_oe),
    .pu_nxt   (c_pun)
  );

  // ***************************************************************
  // wake enables and strength
  // ***************************************************************
  logic [7:0] wake_en_ff;
  logic       strength_ff;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_en_ff  <= bio_pkg::RST_WAKE;
      strength_ff <= bio_pkg::RST_STRENGTH;
    end
    else
    begin
      if (wr_a_wake) wake_en_ff <= reg_wdata & PORT_A_MASK;
      if (wr_str) strength_ff <= reg_wdata[bio_pkg::STRONG_PULLUP_BIT];
    end
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  logic [7:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = bio_pkg::ZERO_BYTE;  // unmapped indices read zero
    case (reg_addr)
      bio_pkg::ADR_PORT_A_DATA:      nxt_rdata = a_rd;
      bio_pkg::ADR_PORT_A_DIRECTION: nxt_rdata = a_dir & PORT_A_MASK;
      bio_pkg::ADR_PORT_A_PULLUP:    nxt_rdata = a_pu;
      bio_pkg::ADR_PORT_A_WAKE:      nxt_rdata = wake_en_ff;
      bio_pkg::ADR_PORT_B_DATA:      nxt_rdata = b_rd;
      bio_pkg::ADR_PORT_B_DIRECTION: nxt_rdata = b_dir & PORT_B_MASK;
      bio_pkg::ADR_PORT_B_PULLUP:    nxt_rdata = b_pu;
      bio_pkg::ADR_PORT_C_DATA:      nxt_rdata = c_rd;
      bio_pkg::ADR_PORT_C_DIRECTION: nxt_rdata = c_dir & PORT_C_MASK;
      bio_pkg::ADR_PORT_C_PULLUP:    nxt_rdata = c_pu;
      bio_pkg::ADR_STRENGTH:
        nxt_rdata = {7'h00, strength_ff};
      default:                       nxt_rdata = bio_pkg::ZERO_BYTE;
    endcase
  end

  // ***************************************************************
  // wake detect
  // ***************************************************************
  // previous pin level for a falling-edge test; pins treated as synchronous
  logic [7:0] a_prev_ff;
  wire logic [7:0] wake_hits = wake_en_ff & a_dir & a_prev_ff & ~port_a_in;
  wire logic       nxt_wake  = core_low_power & (|wake_hits);

  // strength only matters where some pull-high actually is on
  wire logic nxt_strong = strength_ff & (|{a_pun, b_pun, c_pun});

  // ***************************************************************
  // output flops
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_ff     <= bio_pkg::ZERO_BYTE;
      a_prev_ff        <= bio_pkg::ZERO_BYTE;
      port_a_out_ff    <= bio_pkg::ZERO_BYTE;
      port_b_out_ff    <= bio_pkg::ZERO_BYTE;
      port_c_out_ff    <= bio_pkg::ZERO_BYTE;
      port_a_oe_ff     <= bio_pkg::ZERO_BYTE;
      port_b_oe_ff     <= bio_pkg::ZERO_BYTE;
      port_c_oe_ff     <= bio_pkg::ZERO_BYTE;
      port_a_pu_ff     <= bio_pkg::ZERO_BYTE;
      port_b_pu_ff     <= bio_pkg::ZERO_BYTE;
      port_c_pu_ff     <= bio_pkg::ZERO_BYTE;
      strong_pullup_ff <= 1'b0;
      wake_req_ff      <= 1'b0;
    end
    else
    begin
      if (reg_rd) reg_rdata_ff <= nxt_rdata;   // sampled on the read cycle
      a_prev_ff        <= port_a_in;
      port_a_out_ff    <= a_data & a_oe;
      port_b_out_ff    <= b_data & b_oe;
      port_c_out_ff    <= c_data & c_oe;
      port_a_oe_ff     <= a_oe;
      port_b_oe_ff     <= b_oe;
      port_c_oe_ff     <= c_oe;
      port_a_pu_ff     <= a_pun;
      port_b_pu_ff     <= b_pun;
      port_c_pu_ff     <= c_pun;
      strong_pullup_ff <= nxt_strong;
      wake_req_ff      <= nxt_wake;
    end
  end

  // ***************************************************************
  // checks: latches and drivers
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // a latch moves only on its own write strobe
  a_data_hold: assert property (!wr_a_data |=> a_data == $past(a_data))
    else $error("port a latch changed without write");
  a_b_data_hold: assert property (!wr_b_data |=> b_data == $past(b_data))
    else $error("port b latch changed without write");
  a_c_data_hold: assert property (!wr_c_data |=> c_data == $past(c_data))
    else $error("port c latch changed without write");
  // missing pins are stored as inputs so they can never drive
  a_c_dir_write: assert property (wr_c_dir
      |=> c_dir == ($past(reg_wdata) | ~PORT_C_MASK))
    else $error("port c direction not as written");
  // enables and drive values follow the registers one edge later
  a_oe_from_dir: assert property (##1 port_a_oe_ff == (~$past(a_dir) & PORT_A_MASK))
    else $error("port a enable not from direction");
  a_b_oe_dir: assert property (##1 port_b_oe_ff == (~$past(b_dir) & PORT_B_MASK))
    else $error("port b enable not from direction");
  a_c_oe_dir: assert property (##1 port_c_oe_ff == (~$past(c_dir) & PORT_C_MASK))
    else $error("port c enable not from direction");
  a_out_latch: assert property (##1 port_a_out_ff == ($past(a_data) & $past(a_oe)))
    else $error("port a drive not from latch");
  a_b_out_latch: assert property (##1 port_b_out_ff == ($past(b_data) & $past(b_oe)))
    else $error("port b drive not from latch");
  a_c_out_latch: assert property (##1 port_c_out_ff == ($past(c_data) & $past(c_oe)))
    else $error("port c drive not from latch");

  // ***************************************************************
  // checks: reads
  // ***************************************************************
  a_read_mix: assert property (reg_rd && reg_addr == bio_pkg::ADR_PORT_A_DATA
      |=> reg_rdata_ff == ((($past(a_dir) & $past(port_a_in)) |
          (~$past(a_dir) & $past(a_data))) & PORT_A_MASK))
    else $error("port a read mux wrong");
  a_b_read_mix: assert property (reg_rd && reg_addr == bio_pkg::ADR_PORT_B_DATA
      |=> reg_rdata_ff == ((($past(b_dir) & $past(port_b_in)) |
          (~$past(b_dir) & $past(b_data))) & PORT_B_MASK))
    else $error("port b read mux wrong");
  a_c_read_mix: assert property (reg_rd && reg_addr == bio_pkg::ADR_PORT_C_DATA
      |=> reg_rdata_ff == ((($past(c_dir) & $past(port_c_in)) |
          (~$past(c_dir) & $past(c_data))) & PORT_C_MASK))
    else $error("port c read mux wrong");
  // bits without a pin read zero whatever was written to them
  a_unimpl_read: assert property (reg_rd && reg_addr == bio_pkg::ADR_PORT_C_DIRECTION
      |=> (reg_rdata_ff & ~PORT_C_MASK) == 8'h00)
    else $error("port c direction reads unimplemented bits");
  a_strength_read: assert property (reg_rd && reg_addr == bio_pkg::ADR_STRENGTH
      |=> reg_rdata_ff[7:1] == 7'h00)
    else $error("strength register reads upper bits");

  // ***************************************************************
  // checks: pull-high and strength
  // ***************************************************************
  a_pu_gate: assert property (##1
      (port_b_pu_ff & ~($past(b_dir) | $past(port_b_nmos))) == 8'h00)
    else $error("pull-high on while driving cmos");
  a_pu_gate_a: assert property (##1
      (port_a_pu_ff & ~($past(a_dir) | $past(port_a_nmos))) == 8'h00)
    else $error("port a pull-high on while driving cmos");
  a_pu_gate_c: assert property (##1
      (port_c_pu_ff & ~($past(c_dir) | $past(port_c_nmos))) == 8'h00)
    else $error("port c pull-high on while driving cmos");
  // an enabled pull-high on an input pin must reach the pin
  a_pu_enable: assert property (##1
      port_a_pu_ff == ($past(a_pu) & ($past(a_dir) | $past(port_a_nmos)) & PORT_A_MASK))
    else $error("port a pull-high enable lost");
  a_strong_on: assert property (##1
      strong_pullup_ff == ($past(strength_ff) && $past(|{a_pun, b_pun, c_pun})))
    else $error("strength output not from bit and enables");
  a_strong_gate: assert property (strong_pullup_ff
      |-> $past(strength_ff) && $past(|{a_pun, b_pun, c_pun}))
    else $error("strength with bit clear or no pull-high");
  a_unimpl_zero: assert property (
      (((a_data | a_pu | wake_en_ff) & ~PORT_A_MASK) | ((c_data | c_pu) & ~PORT_C_MASK)) == 8'h00)
    else $error("unimplemented bit set");

  // ***************************************************************
  // checks: wake-up
  // ***************************************************************
  a_wake_cause: assert property (wake_req_ff |-> $past(core_low_power)
      && ($past(wake_en_ff & a_dir & ~port_a_in) != 8'h00))
    else $error("wake without enabled input falling");
  a_wake_event: assert property (core_low_power && (wake_hits != 8'h00) |=> wake_req_ff)
    else $error("missed wake");
  a_wake_quiet: assert property (!core_low_power |=> !wake_req_ff)
    else $error("wake while core running");
  // the pin must have been seen high the edge before it was seen low
  a_wake_fall: assert property (wake_req_ff
      |-> ($past(wake_en_ff & ~port_a_in) & $past(port_a_in, 2)) != 8'h00)
    else $error("wake without a high-to-low pin change");

  // main scenarios the bench should reach
  c_wake: cover property (wake_req_ff);
  c_out_drive: cover property (port_a_oe_ff != 8'h00);
  c_strong: cover property (strong_pullup_ff);
  c_read_in: cover property (reg_rd && reg_addr == bio_pkg::ADR_PORT_B_DATA);
  c_nmos_pull: cover property (port_a_pu_ff != 8'h00 && port_a_oe_ff != 8'h00);

endmodule : bio_ports

// [tb/bio_pin_model.sv]
// partner model: switches and loads standing on the three eight-pin port groups
`timescale 1ns/1ps
module bio_pin_model (
  input  wire logic        ref_clk,
  input  wire logic [23:0] sw_en,
  input  wire logic [23:0] sw_val,
  input  wire logic [23:0] oe,
  input  wire logic [23:0] out,
  input  wire logic [23:0] pu,
  output logic      [23:0] pin
);
  // ***************************************************************
  // wire resolution
  // ***************************************************************
  logic [23:0] float_ff = 24'h5a5a5a;

  // a pin with no driver and no pull wanders each cycle so no stale level is trusted
  always @(posedge ref_clk)
  begin
    float_ff <= ~float_ff;
  end

  // the port driver wins over a closed switch, the switch over the pull-high
  assign pin = (oe & out) | (~oe & sw_en & sw_val) | (~oe & ~sw_en & pu)
             | (~oe & ~sw_en & ~pu & float_ff);
endmodule : bio_pin_model

// [tb/bio_ports_bench.sv]
// testbench: register sequences, pin reads, pull-high and wake-up for the io ports
`timescale 1ns/1ps
module bio_ports_bench;
  // ***************************************************************
  // signals and instances
  // ***************************************************************
  logic        ref_clk, nrst, reg_wr, reg_rd, core_low_power, strong_pullup_ff, wake_req_ff;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_ff, nmos_a, rv, m;
  logic [23:0] sw_en, sw_val, pin;
  wire  [23:0] oe_all, out_all, pu_all;
  int          err_total, n_tests, wakes;

  bio_ports bio_ports_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .core_low_power(core_low_power), .port_a_nmos(nmos_a), .port_b_nmos(8'h00),
    .port_c_nmos(8'h00), .port_a_in(pin[7:0]), .port_b_in(pin[15:8]),
    .port_c_in(pin[23:16]), .port_a_out_ff(out_all[7:0]), .port_b_out_ff(out_all[15:8]),
    .port_c_out_ff(out_all[23:16]), .port_a_oe_ff(oe_all[7:0]), .port_b_oe_ff(oe_all[15:8]),
    .port_c_oe_ff(oe_all[23:16]), .port_a_pu_ff(pu_all[7:0]), .port_b_pu_ff(pu_all[15:8]),
    .port_c_pu_ff(pu_all[23:16]), .strong_pullup_ff(strong_pullup_ff),
    .wake_req_ff(wake_req_ff));

  bio_pin_model bio_pin_model_inst (
    .ref_clk(ref_clk), .sw_en(sw_en), .sw_val(sw_val), .oe(oe_all), .out(out_all),
    .pu(pu_all), .pin(pin));

  always #20 ref_clk = ~ref_clk;

  // ***************************************************************
  // access tasks
  // ***************************************************************
  // strobe is raised after one edge and taken at the next
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask : rd

  // outputs come from a second flop stage, so one more edge before looking
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // a clean high-to-low on pin a0, then count wake pulses over four edges
  task automatic wake_try(input logic lp, input int exp);
    @(posedge ref_clk);
    core_low_power <= lp; sw_val[0] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sw_val[0] <= 1'b0;
    wakes = 0;
    repeat (4)
    begin
      @(posedge ref_clk);
      #1 if (wake_req_ff === 1'b1) wakes++;
    end
    check("wake pulses", 8'(wakes), 8'(exp));
  endtask : wake_try

  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    core_low_power = 1'b0; nmos_a = 8'h00; sw_en = 24'hffffff; sw_val = 24'h3c96a5;
    err_total = 0; n_tests = 0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    // every index after reset: pins on data, all-input directions, zeros elsewhere
    for (int i = 0; i < 16; i++)
    begin
      m = (i >= 8) ? 8'h3f : 8'hff;
      rd(4'(i), rv);
      if (i >= 12) check("reset unmapped", rv, 8'h00);
      else if (i % 4 == 0) check("reset data", rv, sw_val[(i/4)*8 +: 8] & m);
      else if (i % 4 == 1) check("reset dir", rv, m);
      else check("reset pullup wake", rv, 8'h00);
    end
    // per port: low nibble outputs, reads mix latch and live pins
    for (int p = 0; p < 3; p++)
    begin
      m = (p == 2) ? 8'h3f : 8'hff;
      wr(4'(p * 4 + 1), 8'hf0);
      wr(4'(p * 4), 8'ha5);
      wr(4'(p * 4 + 2), 8'hff);
      settle();
      check("oe", oe_all[p*8 +: 8], 8'h0f & m);
      check("out", out_all[p*8 +: 8], 8'h05);
      check("pullup", pu_all[p*8 +: 8], 8'hf0 & m);
      rd(4'(p * 4), rv);
      check("read mix", rv, (8'h05 | (sw_val[p*8 +: 8] & 8'hf0)) & m);
      @(posedge ref_clk);
      sw_val[p*8 +: 8] <= ~sw_val[p*8 +: 8];
      rd(4'(p * 4), rv);
      check("read after flip", rv, (8'h05 | (sw_val[p*8 +: 8] & 8'hf0)) & m);
    end
    // nmos output may take the pull-high; strength only with some pull-high on
    @(posedge ref_clk);
    nmos_a <= 8'h01;
    settle();
    check("pullup nmos", pu_all[7:0], 8'hf1);
    check("strength reset", {7'h00, strong_pullup_ff}, 8'h00);
    wr(bio_pkg::ADR_STRENGTH, 8'hff);
    settle();
    check("strength on", {7'h00, strong_pullup_ff}, 8'h01);
    rd(bio_pkg::ADR_STRENGTH, rv);
    check("strength read", rv, 8'h01);
    for (int p = 0; p < 3; p++) wr(4'(p * 4 + 2), 8'h00);
    settle();
    check("strength no pullup", {7'h00, strong_pullup_ff}, 8'h00);
    check("pullups off", pu_all[7:0], 8'h00);
    wr(4'h7, 8'hff);
    rd(4'h7, rv);
    check("unmapped", rv, 8'h00);
    // wake-up on pin a0
    wr(bio_pkg::ADR_PORT_A_DIRECTION, 8'hff);
    wr(bio_pkg::ADR_PORT_A_WAKE, 8'h01);
    wake_try(1'b1, 1);
    wake_try(1'b0, 0);
    wr(bio_pkg::ADR_PORT_A_DIRECTION, 8'hfe);
    wake_try(1'b1, 0);
    // an output pin falling under its own latch must not wake the core
    wr(bio_pkg::ADR_PORT_A_DATA, 8'h00);
    wakes = 0;
    repeat (4)
    begin
      @(posedge ref_clk);
      #1 if (wake_req_ff === 1'b1) wakes++;
    end
    check("wake from output", 8'(wakes), 8'h00);
    wr(bio_pkg::ADR_PORT_A_DIRECTION, 8'hff);
    wr(bio_pkg::ADR_PORT_A_WAKE, 8'h00);
    wake_try(1'b1, 0);
    complete_run();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end
endmodule : bio_ports_bench
